// ===== hdl/pms_pkg.sv
// Package: register map, frame layout and timing constants for the management controller
// Contract
// - Poll all 32 transceiver addresses in repeating sequence
// - Serial management protocol on shared two-wire bus
// - Only first controller channel is functional
// - Alive and link bit per transceiver address
// - Link change interrupt, raw and masked views
// - Command complete flag, masks set and clear
// - Software reads and writes transceiver registers
package pms_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_REVISION = 32'h01c8_3800;
  localparam logic [31:0] ADDR_CONTROL = 32'h01c8_3804;
  localparam logic [31:0] ADDR_ALIVE = 32'h01c8_3808;
  localparam logic [31:0] ADDR_LINK = 32'h01c8_380c;
  localparam logic [31:0] ADDR_LINK_RAW = 32'h01c8_3810;
  localparam logic [31:0] ADDR_LINK_MASKED = 32'h01c8_3814;
  localparam logic [31:0] ADDR_DONE_RAW = 32'h01c8_3818;
  localparam logic [31:0] ADDR_DONE_MASKED = 32'h01c8_381c;
  localparam logic [31:0] ADDR_DONE_EN_SET = 32'h01c8_3820;
  localparam logic [31:0] ADDR_DONE_EN_CLR = 32'h01c8_3824;
  localparam logic [31:0] ADDR_USER_0 = 32'h01c8_3828;
  localparam logic [31:0] ADDR_USER_1 = 32'h01c8_382c;
  localparam logic [31:0] ADDR_SELECT_0 = 32'h01c8_3830;
  localparam logic [31:0] ADDR_SELECT_1 = 32'h01c8_3834;

  // Arbitrary value, carries no meaning
  localparam logic [31:0] REVISION_VALUE = 32'h0001_0000;

  // Control fields
  localparam int CTRL_IDLE_BIT = 31;
  localparam int CTRL_ENABLE_BIT = 30;
  localparam logic CTRL_ENABLE_RESET = 1'b1;

  // First controller bit of the interrupt registers
  localparam int CHAN0_BIT = 0;

  // User transaction fields
  localparam int UA_GO_BIT = 31;
  localparam int UA_WRITE_BIT = 30;
  localparam int UA_ACK_BIT = 29;
  localparam int UA_REG_LSB = 21;
  localparam int UA_PHY_LSB = 16;

  // Transceiver select fields
  localparam int SEL_LINKINT_BIT = 6;
  localparam int SEL_PHY_LSB = 0;

  // Frame layout, bit index counted from the first preamble bit
  localparam logic [31:0] FRAME_PREAMBLE = 32'hffff_ffff;
  localparam logic [1:0] FRAME_START = 2'h1;
  localparam logic [1:0] FRAME_OP_READ = 2'h2;
  localparam logic [1:0] FRAME_OP_WRITE = 2'h1;
  localparam logic [1:0] FRAME_TA_WRITE = 2'h2;
  localparam logic [1:0] FRAME_TA_READ = 2'h3;
  localparam logic [5:0] FRAME_RELEASE_BIT = 6'h2e;
  localparam logic [5:0] FRAME_ACK_BIT = 6'h2f;
  localparam logic [5:0] FRAME_DATA_BIT = 6'h30;
  localparam logic [5:0] FRAME_LAST_BIT = 6'h3f;

  // Polled transceiver register and its link bit
  localparam logic [4:0] POLL_REG = 5'h01;
  localparam int LINK_STATUS_BIT = 2;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int MDC_HALF_NS = 200;
  localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] MDC_HALF_LAST = 6'(MDC_HALF_CYC - 1);

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FRAME = 2'h1,
    ST_DONE = 2'h3
  } pms_state_e;

  typedef struct packed {
    logic write;
    logic [4:0] phy;
    logic [4:0] regad;
    logic [15:0] data;
  } pms_cmd_s;

endpackage

// ===== hdl/pms_sync.sv
// Two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pms_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire

// ===== hdl/pms_ctrl.sv
// Management bus controller: register slave, polling and frame engine
`timescale 1ns/1ps
`default_nettype none
module pms_ctrl
  import pms_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Management bus
  output logic management_clock,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic mdio_i,
  // Interrupt
  output logic irq
);

  // Bus slave state
  logic aw_full_q;
  logic [31:0] aw_addr_q;
  logic w_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Register state
  logic ctrl_enable_q;
  logic [31:0] alive_q;
  logic [31:0] link_q;
  logic link_raw_q;
  logic done_raw_q;
  logic done_en_q;
  logic ua_go_q;
  logic ua_ack_q;
  pms_cmd_s ua_cmd_q;
  logic [4:0] sel_phy_q;
  logic sel_linkint_q;

  // Frame engine state
  pms_state_e state_q;
  logic [5:0] div_q;
  logic mdc_q;
  logic [5:0] bit_q;
  logic [63:0] frame_q;
  logic oe_q;
  logic ack_q;
  logic [15:0] rx_q;
  logic user_frame_q;
  logic [4:0] poll_addr_q;

  logic mdio_in_s;

  pms_sync #(
    .WIDTH(1)
  ) u_mdio_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(mdio_i),
    .sync_out(mdio_in_s)
  );

  // Write path decode
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wbits = w_data_q & wmask;
  wire wr_control = do_write & (aw_addr_q == ADDR_CONTROL);
  wire wr_link_clr = do_write & ((aw_addr_q == ADDR_LINK_RAW) | (aw_addr_q == ADDR_LINK_MASKED));
  wire wr_done_clr = do_write & ((aw_addr_q == ADDR_DONE_RAW) | (aw_addr_q == ADDR_DONE_MASKED));
  wire wr_en_set = do_write & (aw_addr_q == ADDR_DONE_EN_SET);
  wire wr_en_clr = do_write & (aw_addr_q == ADDR_DONE_EN_CLR);
  wire wr_user = do_write & (aw_addr_q == ADDR_USER_0);
  wire wr_select = do_write & (aw_addr_q == ADDR_SELECT_0);
  wire wr_mapped = (aw_addr_q[31:6] == ADDR_REVISION[31:6]) & (aw_addr_q[5:2] <= 4'hd)
    & (aw_addr_q[1:0] == 2'h0);

  // Read path decode
  wire ar_take = s_axi_arvalid & ~rvalid_q;
  wire rd_mapped = (s_axi_araddr[31:6] == ADDR_REVISION[31:6]) & (s_axi_araddr[5:2] <= 4'hd)
    & (s_axi_araddr[1:0] == 2'h0);
  wire rd_link_raw = ar_take & (s_axi_araddr == ADDR_LINK_RAW);
  wire rd_done_raw = ar_take & (s_axi_araddr == ADDR_DONE_RAW);

  // Interrupt views; only the first controller bit exists
  wire link_masked = link_raw_q & sel_linkint_q;
  wire done_masked = done_raw_q & done_en_q;
  wire [31:0] ctrl_view = {~ua_go_q & (state_q == ST_IDLE), ctrl_enable_q, 30'h0};
  wire [31:0] user_view = {ua_go_q, ua_cmd_q.write, ua_ack_q, 3'h0, ua_cmd_q.regad,
    ua_cmd_q.phy, ua_cmd_q.data};
  wire [31:0] sel_view = {25'h0, sel_linkint_q, 1'b0, sel_phy_q};
  // Second-controller and reserved words read as zero
  wire [31:0] rd_value =
    (s_axi_araddr == ADDR_REVISION) ? REVISION_VALUE :
    (s_axi_araddr == ADDR_CONTROL) ? ctrl_view :
    (s_axi_araddr == ADDR_ALIVE) ? alive_q :
    (s_axi_araddr == ADDR_LINK) ? link_q :
    (s_axi_araddr == ADDR_LINK_RAW) ? {31'h0, link_raw_q} :
    (s_axi_araddr == ADDR_LINK_MASKED) ? {31'h0, link_masked} :
    (s_axi_araddr == ADDR_DONE_RAW) ? {31'h0, done_raw_q} :
    (s_axi_araddr == ADDR_DONE_MASKED) ? {31'h0, done_masked} :
    (s_axi_araddr == ADDR_DONE_EN_SET) ? {31'h0, done_en_q} :
    (s_axi_araddr == ADDR_DONE_EN_CLR) ? {31'h0, done_en_q} :
    (s_axi_araddr == ADDR_USER_0) ? user_view :
    (s_axi_araddr == ADDR_SELECT_0) ? sel_view :
    32'h0000_0000;

  // Frame engine decode
  wire div_wrap = (div_q == MDC_HALF_LAST);
  wire rise_evt = (state_q == ST_FRAME) & div_wrap & ~mdc_q;
  wire fall_evt = (state_q == ST_FRAME) & div_wrap & mdc_q;
  wire frame_end = fall_evt & (bit_q == FRAME_LAST_BIT);
  wire start_frame = (state_q == ST_IDLE) & ctrl_enable_q;
  wire poll_done = (state_q == ST_DONE) & ~user_frame_q;
  wire user_done = (state_q == ST_DONE) & user_frame_q;
  wire poll_link = ack_q & rx_q[LINK_STATUS_BIT];
  wire link_event = poll_done & (poll_addr_q == sel_phy_q) & (poll_link != link_q[poll_addr_q]);

  // Write or read of the frame in flight
  logic user_write_now;
  assign user_write_now = user_frame_q & ua_cmd_q.write;

  // User access has priority over the background poll
  pms_cmd_s next_cmd;
  assign next_cmd = ua_go_q ? ua_cmd_q : '{write: 1'b0, phy: poll_addr_q, regad: POLL_REG,
    data: 16'h0000};
  wire [63:0] next_frame = {FRAME_PREAMBLE, FRAME_START,
    next_cmd.write ? FRAME_OP_WRITE : FRAME_OP_READ, next_cmd.phy, next_cmd.regad,
    next_cmd.write ? FRAME_TA_WRITE : FRAME_TA_READ, next_cmd.data};

  // Bus slave handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_value;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Software-written configuration
  // Writes to the second user words and second-controller bits have no effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_enable_q <= CTRL_ENABLE_RESET;
      done_en_q <= 1'b0;
      sel_phy_q <= 5'h00;
      sel_linkint_q <= 1'b0;
    end else begin
      if (wr_control & w_strb_q[3]) begin
        ctrl_enable_q <= w_data_q[CTRL_ENABLE_BIT];
      end
      if (wr_en_set & wbits[CHAN0_BIT]) begin
        done_en_q <= 1'b1;
      end else if (wr_en_clr & wbits[CHAN0_BIT]) begin
        done_en_q <= 1'b0;
      end
      if (wr_select & w_strb_q[0]) begin
        sel_phy_q <= w_data_q[SEL_PHY_LSB +: 5];
        sel_linkint_q <= w_data_q[SEL_LINKINT_BIT];
      end
    end
  end

  // Sticky flags: a new event wins over a read or write clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_raw_q <= 1'b0;
      done_raw_q <= 1'b0;
    end else begin
      link_raw_q <= link_event | (link_raw_q & ~rd_link_raw
        & ~(wr_link_clr & wbits[CHAN0_BIT]));
      done_raw_q <= user_done | (done_raw_q & ~rd_done_raw
        & ~(wr_done_clr & wbits[CHAN0_BIT]));
    end
  end

  // User transaction word; ignored while a command is in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ua_go_q <= 1'b0;
      ua_ack_q <= 1'b0;
      ua_cmd_q <= '0;
    end else if (user_done) begin
      ua_go_q <= 1'b0;
      ua_ack_q <= ack_q;
      if (!ua_cmd_q.write) begin
        ua_cmd_q.data <= rx_q;
      end
    end else if (wr_user & ~ua_go_q & (&w_strb_q)) begin
      ua_go_q <= w_data_q[UA_GO_BIT];
      ua_cmd_q.write <= w_data_q[UA_WRITE_BIT];
      ua_cmd_q.regad <= w_data_q[UA_REG_LSB +: 5];
      ua_cmd_q.phy <= w_data_q[UA_PHY_LSB +: 5];
      ua_cmd_q.data <= w_data_q[15:0];
    end
  end

  // Poll results per address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alive_q <= 32'h0000_0000;
      link_q <= 32'h0000_0000;
      poll_addr_q <= 5'h00;
    end else if (poll_done) begin
      alive_q[poll_addr_q] <= ack_q;
      link_q[poll_addr_q] <= poll_link;
      poll_addr_q <= poll_addr_q + 5'h01;
    end
  end

  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      user_frame_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_frame) begin
            state_q <= ST_FRAME;
            user_frame_q <= ua_go_q;
          end
        end
        ST_FRAME: begin
          if (frame_end) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Clock divider and shifter; data changes after the falling edge
  // and input is taken at the rising edge, as the transceiver expects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 6'h00;
      mdc_q <= 1'b0;
      bit_q <= 6'h00;
      frame_q <= 64'h0000_0000_0000_0000;
      oe_q <= 1'b0;
    end else if (start_frame) begin
      div_q <= 6'h00;
      mdc_q <= 1'b0;
      bit_q <= 6'h00;
      frame_q <= next_frame;
      oe_q <= 1'b1;
    end else if (state_q == ST_FRAME) begin
      div_q <= div_wrap ? 6'h00 : div_q + 6'h01;
      if (div_wrap) begin
        mdc_q <= ~mdc_q;
      end
      if (frame_end) begin
        oe_q <= 1'b0;
      end else if (fall_evt) begin
        bit_q <= bit_q + 6'h01;
        frame_q <= {frame_q[62:0], 1'b0};
        // Read frames hand the line to the transceiver at turnaround
        if ((bit_q + 6'h01 == FRAME_RELEASE_BIT) & ~user_write_now) begin
          oe_q <= 1'b0;
        end
      end
    end
  end

  // Turnaround acknowledge and read data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_q <= 1'b0;
      rx_q <= 16'h0000;
    end else if (start_frame) begin
      ack_q <= 1'b0;
      rx_q <= 16'h0000;
    end else if (rise_evt) begin
      if (bit_q == FRAME_ACK_BIT) begin
        ack_q <= user_write_now | ~mdio_in_s;
      end
      if ((bit_q >= FRAME_DATA_BIT) & ~user_write_now) begin
        rx_q <= {rx_q[14:0], mdio_in_s};
      end
    end
  end

  // Outputs
  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready = ~w_full_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign management_clock = mdc_q;
  assign mdio_o = frame_q[63];
  assign mdio_oe = oe_q;
  // Single output for both events; level until flag or enable is cleared
  assign irq = link_masked | done_masked;

endmodule
`default_nettype wire

// ===== testbench/pms_ctrl_assertions.sv
// Port-level checks on the management controller
`timescale 1ns/1ps
`default_nettype none
module pms_ctrl_assertions
  import pms_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Management bus and interrupt
  input wire logic management_clock,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] hi_q;
  logic [13:0] st_q;
  logic oe_q;
  logic [31:0] ar_q;
  // Saturating frame age, so idle time never wraps into a false spacing
  always_ff @(posedge aclk) begin
    oe_q <= mdio_oe;
    hi_q <= management_clock ? hi_q + 8'h01 : 8'h00;
    if (!aresetn) st_q <= 14'h3fff;
    else if (mdio_oe && !oe_q) st_q <= 14'h0001;
    else if (st_q != 14'h3fff) st_q <= st_q + 14'h0001;
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  a_bresp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early");
  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped early");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("Write response late");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data late");
  a_clock_high: assert property (
    $fell(management_clock) |-> hi_q == 8'h28)
    else $error("Bus clock high phase wrong");
  a_data_on_fall: assert property (
    mdio_oe && $changed(mdio_o) |-> $fell(management_clock) || $rose(mdio_oe))
    else $error("Data moved outside falling clock");
  a_preamble_ones: assert property (
    mdio_oe && st_q < 14'h0a00 |-> mdio_o)
    else $error("Preamble bit not one");
  a_frame_spacing: assert property (
    $rose(mdio_oe) && st_q != 14'h3fff |-> st_q >= 14'h1400 && st_q <= 14'h1404)
    else $error("Frame spacing wrong");
  a_reserved_zero: assert property (
    $rose(s_axi_rvalid) && ar_q == ADDR_USER_1 |-> s_axi_rdata == 32'h0000_0000)
    else $error("Reserved user word not zero");
  c_irq: cover property ($rose(irq));
  c_release: cover property ($fell(mdio_oe));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind pms_ctrl pms_ctrl_assertions u_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .management_clock(management_clock), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
  .irq(irq)
);
`default_nettype wire

// ===== testbench/pms_phy_model.sv
// Behavioural transceiver on the management bus
`timescale 1ns/1ps
`default_nettype none
module pms_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Management bus
  input wire logic management_clock,
  input wire logic line,
  output logic drv_oe,
  output logic drv_o
);
  logic [15:0] regs [32];
  logic [63:0] sr;
  logic [1:0] op;
  logic [4:0] ph, ra;
  logic busy;
  int rc;
  initial begin
    foreach (regs[i]) regs[i] = 16'h0000;
    regs[1] = 16'h0004;
    {sr, op, ph, ra, busy, drv_oe, drv_o} = '0;
    rc = 0;
  end
  // Hunt for preamble and start, then decode header
  always @(posedge management_clock) begin
    sr = {sr[62:0], line};
    if (busy) rc++;
    if (!busy && sr[33:0] == 34'h3_ffff_fffd) begin
      busy = 1'b1;
      rc = 34;
    end
    if (rc == 46) {op, ph, ra} = sr[11:0];
    if (rc == 64 && op == 2'h1 && ph == PHY_ADDR) regs[ra] = sr[15:0];
  end
  // Drive acknowledge and data, msb first, on falling clock
  always @(negedge management_clock) begin
    if (busy && op == 2'h2 && ph == PHY_ADDR && rc >= 47 && rc <= 63) begin
      drv_oe = 1'b1;
      drv_o = (rc == 47) ? 1'b0 : regs[ra][63 - rc];
    end
    if (rc == 64) begin
      busy = 1'b0;
      drv_oe = 1'b0;
      rc = 0;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/pms_ctrl_test.sv
// Self-checking bench: register bus, polling, interrupts and user frames
`timescale 1ns/1ps
`default_nettype none
module pms_ctrl_test import pms_pkg::*;;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, mdc, mo, moe, line, po, poe, irq;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0] bresp, rresp;
  logic [15:0] seed;
  logic [3:0] wstrb;
  logic [65:0] expq[$];
  logic [65:0] e;
  int err_count, compares;
  // Pull-up holds the released line high
  assign line = moe ? mo : (poe ? po : 1'b1);
  pms_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .management_clock(mdc), .mdio_o(mo), .mdio_oe(moe),
    .mdio_i(line), .irq(irq));
  pms_phy_model #(.PHY_ADDR(5'h01)) phy (.management_clock(mdc), .line(line),
    .drv_oe(poe), .drv_o(po));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic ok);
    compares++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t level or model state wrong", $time);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    expq.push_back({r, 64'h0000_0000_0000_0000});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] x,
                    input logic [1:0] r);
    @(posedge aclk);
    expq.push_back({r, m, x});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
  endtask
  task automatic wait_irq(input logic want);
    repeat (12000) begin
      @(posedge aclk);
      if (irq === want) break;
    end
    chk(irq === want);
  endtask
  task automatic tally_and_finish();
    $display("Compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Oldest note is matched against each bus answer
  always @(posedge aclk) begin
    if ((rvalid === 1'b1 && rready) || (bvalid === 1'b1 && bready)) begin
      e = expq.pop_front();
      compares++;
      if ((rvalid ? {rresp, rdata & e[63:32]} : {bresp, 32'h0000_0000}) !== {e[65:64], e[31:0]})
      begin
        err_count++;
        $display("[ERR] %0t bus answer mismatch", $time);
      end
    end
  end
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    err_count = 0;
    compares = 0;
    seed = 16'h0023;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_REVISION, 32'hffff_ffff, REVISION_VALUE, RESP_OKAY);
    rd(ADDR_CONTROL, 32'h4000_0000, 32'h4000_0000, RESP_OKAY);
    rd(ADDR_USER_1, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY);
    rd(ADDR_SELECT_1, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY);
    rd(32'h01c8_3838, 32'hffff_ffff, 32'h0000_0000, RESP_SLVERR);
    wr(32'h01c8_3900, 32'h0000_0000, RESP_SLVERR);
    $display("Register map test done");
    wr(ADDR_SELECT_0, 32'h0000_0041, RESP_OKAY);
    wr(ADDR_DONE_EN_SET, 32'h0000_0001, RESP_OKAY);
    rd(ADDR_DONE_EN_CLR, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
    wait_irq(1'b1);
    rd(ADDR_ALIVE, 32'h0000_0003, 32'h0000_0002, RESP_OKAY);
    rd(ADDR_LINK, 32'h0000_0003, 32'h0000_0002, RESP_OKAY);
    rd(ADDR_LINK_MASKED, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
    rd(ADDR_LINK_RAW, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
    rd(ADDR_LINK_RAW, 32'h0000_0001, 32'h0000_0000, RESP_OKAY);
    wait_irq(1'b0);
    // Lane 0 off: the select word must keep its value
    wstrb <= 4'he;
    wr(ADDR_SELECT_0, 32'h0000_0003, RESP_OKAY);
    wstrb <= 4'hf;
    rd(ADDR_SELECT_0, 32'h0000_007f, 32'h0000_0041, RESP_OKAY);
    $display("Polling test done");
    seed = lfsr(lfsr(seed));
    wr(ADDR_USER_0, {2'h3, 4'h0, 5'h05, 5'h01, seed}, RESP_OKAY);
    wait_irq(1'b1);
    chk(phy.regs[5] === seed);
    rd(ADDR_DONE_MASKED, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
    rd(ADDR_DONE_RAW, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
    wait_irq(1'b0);
    $display("User write test done");
    wr(ADDR_DONE_EN_CLR, 32'h0000_0001, RESP_OKAY);
    rd(ADDR_DONE_EN_SET, 32'h0000_0001, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_USER_0, {2'h2, 4'h0, 5'h05, 5'h01, 16'h0000}, RESP_OKAY);
    // Worst case: rest of a poll frame plus the user frame
    repeat (10300) @(posedge aclk);
    chk(irq === 1'b0);
    rd(ADDR_DONE_RAW, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
    rd(ADDR_USER_0, 32'ha000_ffff, {16'h2000, seed}, RESP_OKAY);
    $display("User read test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
